// ==== hw/uss_pkg.sv ====
/*
  Register map, field positions, reset values and carrier types of the
  synchronous slave serial port.
  Assumes byte-wide registers, one per aligned word of a 32-bit bus.
*/
package uss_pkg;
  localparam int ADDR_W = 8;
  // Register offsets
  localparam logic [7:0] OFF_RX_CTL = 8'h00;
  localparam logic [7:0] OFF_TX_CTL = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_RX_DATA = 8'h0c;
  localparam logic [7:0] OFF_TX_DATA = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN1 = 8'h14;
  localparam logic [7:0] OFF_IRQ_FLG1 = 8'h18;
  localparam logic [7:0] OFF_CORE_IRQ = 8'h1c;
  localparam logic [7:0] OFF_ALT_PIN = 8'h20;
  localparam logic [7:0] OFF_ANALOG = 8'h24;
  localparam logic [7:0] OFF_EVT_STAT = 8'h28;
  localparam logic [7:0] OFF_EVT_MASK = 8'h2c;
  // receive_control_status fields
  localparam int B_PORT_EN = 7;
  localparam int B_RX9_EN = 6;
  localparam int B_SINGLE_RX = 5;
  localparam int B_CONT_RX = 4;
  localparam int B_OVERRUN = 1;
  localparam int B_RX_NINTH = 0;
  // transmit_control_status fields
  localparam int B_CLK_SRC = 7;
  localparam int B_TX9_EN = 6;
  localparam int B_TX_EN = 5;
  localparam int B_SYNC_MODE = 4;
  localparam int B_SR_EMPTY = 1;
  localparam int B_TX_NINTH = 0;
  // baud_control fields
  localparam int B_RX_IDLE = 6;
  localparam int B_CLK_POL = 4;
  // Interrupt enable / flag / core control fields
  localparam int B_RX_IE = 5;
  localparam int B_TX_IE = 4;
  localparam int B_RX_FLAG = 5;
  localparam int B_TX_FLAG = 4;
  localparam int B_GLOBAL_IE = 7;
  localparam int B_PERIPH_IE = 6;
  // Pin placement and analog selection
  localparam int B_DATA_ALT = 7;
  localparam int B_CLK_ALT = 2;
  localparam int B_ANA_CLK = 0;
  localparam int B_ANA_DATA = 1;
  // Sticky events
  localparam int N_EVT = 3;
  localparam int E_RX = 0;
  localparam int E_TX = 1;
  localparam int E_OVR = 2;
  // Reset values and constants
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_ANALOG = 8'h03;
  localparam logic [11:0] IRQ_VECTOR = 12'h004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } uss_word_t;

  typedef struct packed {
    logic [1:0] clk;
    logic [1:0] data;
  } uss_pins_t;
endpackage

// ==== hw/uss_top.sv ====
/*
  Synchronous slave serial port: aclk shift registers stepped on edges of the external
  master's clock, receive FIFO, transmit holding buffer, sleep wake logic
  and an AXI4-Lite register slave.
  Assumes the pins are asynchronous to aclk and that the link clock is
  well below aclk/4, so every edge is seen after synchronisation.
*/
module uss_top
  import uss_pkg::*;
#(
  parameter int RX_DEPTH = 2
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire logic core_sleeping,
  output logic core_wake,
  output logic core_irq,
  output logic [11:0] core_irq_vector,
  output logic irq,
  // Pins, index 0 default location, 1 alternate
  input wire logic [1:0] shift_clock_pin,
  input wire logic [1:0] data_pin_in,
  output logic [1:0] data_pin_out,
  output logic [1:0] data_pin_oe_n
);
  localparam int PW = RX_DEPTH > 1 ? $clog2(RX_DEPTH) : 1;
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(RX_DEPTH);

  logic [7:0] rcs_q, txs_q, bdc_q, pie_q, icn_q, apf_q, ana_q;
  logic [N_EVT-1:0] evt_q, msk_q, evt_set;
  uss_pins_t pin_m_q, pin_s_q;
  logic ck_prev_q, ck_lvl, dt_lvl, samp;
  logic slave, rx_on, tx_mode;
  logic [3:0] rx_cnt_q, tx_cnt_q;
  logic [8:0] rsr_q, rx_next;
  uss_word_t rx_word, hold_q;
  uss_word_t fifo_q [RX_DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [CW-1:0] fcnt_q;
  logic rx_last, rx_done, push, pop, full, ovr_q, ovr_set, receive_complete_flag, transmit_buffer_empty_flag;
  logic [8:0] tsr_q;
  logic tsr_full_q, hold_full_q, tx_last, samp_tx, tx_done, move, wr_tx;
  logic aw_ok_q, w_ok_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] wbyte_q;
  logic wr_fire, rd_fire, wr_map;
  logic [7:0] rd_val;
  logic rd_map;

  // Pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end
    else
    begin
      pin_m_q <= '{clk: shift_clock_pin, data: data_pin_in};
      pin_s_q <= pin_m_q;
    end
  end

  // Pin selection, analog gating and clock polarity
  assign ck_lvl = (pin_s_q.clk[apf_q[B_CLK_ALT]] & ~ana_q[B_ANA_CLK]) ^ bdc_q[B_CLK_POL];
  assign dt_lvl = pin_s_q.data[apf_q[B_DATA_ALT]] & ~ana_q[B_ANA_DATA];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ck_prev_q <= 1'b0;
    else
      ck_prev_q <= ck_lvl;
  end

  // Sampling edge of the external clock; the only shift timing
  assign samp = ck_prev_q & ~ck_lvl;
  assign slave = txs_q[B_SYNC_MODE] & rcs_q[B_PORT_EN] & ~txs_q[B_CLK_SRC];
  assign rx_on = slave & rcs_q[B_CONT_RX] & ~ovr_q;
  assign tx_mode = slave & txs_q[B_TX_EN] & ~rcs_q[B_CONT_RX] & ~rcs_q[B_SINGLE_RX];

  // Receive shift register
  assign rx_next = {dt_lvl, rsr_q[8:1]};
  assign rx_last = rx_cnt_q == (rcs_q[B_RX9_EN] ? 4'h8 : 4'h7);
  assign rx_done = rx_on & samp & rx_last;
  assign rx_word = rcs_q[B_RX9_EN] ? rx_next : {1'b0, rx_next[8:1]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_on)
    begin
      rx_cnt_q <= '0;
      rsr_q <= '0;
    end
    else if (samp)
    begin
      rsr_q <= rx_next;
      rx_cnt_q <= rx_last ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // Receive FIFO
  assign full = fcnt_q == FULL_CNT;
  assign push = rx_done & ~full;
  assign ovr_set = rx_done & full;
  assign pop = rd_fire & (s_axi_araddr == OFF_RX_DATA) & (fcnt_q != '0);
  assign receive_complete_flag = fcnt_q != '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rcs_q[B_PORT_EN])
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fcnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        fifo_q[wr_ptr_q] <= rx_word;
        wr_ptr_q <= (32'(wr_ptr_q) == RX_DEPTH - 1) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
        rd_ptr_q <= (32'(rd_ptr_q) == RX_DEPTH - 1) ? '0 : rd_ptr_q + 1'b1;
      fcnt_q <= fcnt_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rcs_q[B_PORT_EN] || !rcs_q[B_CONT_RX])
      ovr_q <= 1'b0;
    else if (ovr_set)
      ovr_q <= 1'b1;
  end

  // Transmit holding and shift registers
  assign tx_last = tx_cnt_q == (txs_q[B_TX9_EN] ? 4'h8 : 4'h7);
  assign samp_tx = tx_mode & samp & tsr_full_q;
  assign tx_done = samp_tx & tx_last;
  assign move = hold_full_q & (~tsr_full_q | tx_done);
  assign wr_tx = wr_fire & (aw_addr_q == OFF_TX_DATA);
  assign transmit_buffer_empty_flag = ~hold_full_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rcs_q[B_PORT_EN])
    begin
      tsr_q <= '0;
      tsr_full_q <= 1'b0;
      hold_full_q <= 1'b0;
      hold_q <= '0;
      tx_cnt_q <= '0;
    end
    else
    begin
      if (move)
      begin
        tsr_q <= hold_q;
        tsr_full_q <= 1'b1;
        hold_full_q <= 1'b0;
        tx_cnt_q <= '0;
      end
      else if (tx_done)
      begin
        tsr_full_q <= 1'b0;
        tx_cnt_q <= '0;
      end
      else if (samp_tx)
      begin
        tsr_q <= {1'b0, tsr_q[8:1]};
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      if (wr_tx && (!hold_full_q || move))
      begin
        hold_q <= {txs_q[B_TX9_EN] & txs_q[B_TX_NINTH], wbyte_q};
        hold_full_q <= 1'b1;
      end
    end
  end

  // Data pin drive, enable low while in transmit mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_pin_out <= '0;
      data_pin_oe_n <= 2'h3;
    end
    else
    begin
      data_pin_out <= apf_q[B_DATA_ALT] ? {tsr_q[0], 1'b0} : {1'b0, tsr_q[0]};
      data_pin_oe_n <= ~({1'b0, tx_mode} << apf_q[B_DATA_ALT]);
    end
  end

  // Sticky events, cleared by reading the status; a new event wins
  assign evt_set[E_RX] = push;
  assign evt_set[E_TX] = move & tsr_full_q;
  assign evt_set[E_OVR] = ovr_set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_q <= '0;
    else if (rd_fire && s_axi_araddr == OFF_EVT_STAT)
      evt_q <= evt_set;
    else
      evt_q <= evt_q | evt_set;
  end

  // Interrupt, wake and vector outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
      core_irq <= 1'b0;
      core_wake <= 1'b0;
      core_irq_vector <= '0;
    end
    else
    begin
      irq <= |(evt_q & msk_q);
      core_irq <= icn_q[B_GLOBAL_IE] & icn_q[B_PERIPH_IE]
        & ((receive_complete_flag & pie_q[B_RX_IE]) | (transmit_buffer_empty_flag & pie_q[B_TX_IE]));
      core_wake <= core_sleeping & ((receive_complete_flag & pie_q[B_RX_IE])
        | (transmit_buffer_empty_flag & pie_q[B_TX_IE] & icn_q[B_PERIPH_IE]));
      core_irq_vector <= icn_q[B_GLOBAL_IE] ? IRQ_VECTOR : 12'h000;
    end
  end

  // AXI write: address and data taken in either order
  assign wr_fire = aw_ok_q & w_ok_q & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      aw_addr_q <= '0;
      wbyte_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q <= s_axi_awaddr;
        aw_ok_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wbyte_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        w_ok_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready && !s_axi_wstrb[0])
        w_ok_q <= 1'b1;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_map = aw_addr_q inside {OFF_RX_CTL, OFF_TX_CTL, OFF_BAUD, OFF_RX_DATA, OFF_TX_DATA,
    OFF_IRQ_EN1, OFF_IRQ_FLG1, OFF_CORE_IRQ, OFF_ALT_PIN, OFF_ANALOG, OFF_EVT_STAT, OFF_EVT_MASK};

  // Control registers; a write with lane 0 off leaves the byte alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rcs_q <= RST_CTL;
      txs_q <= RST_CTL;
      bdc_q <= RST_CTL;
      pie_q <= RST_CTL;
      icn_q <= RST_CTL;
      apf_q <= RST_CTL;
      ana_q <= RST_ANALOG;
      msk_q <= '0;
    end
    else if (wr_fire && wbyte_q_valid())
    begin
      unique case (aw_addr_q)
        OFF_RX_CTL: rcs_q <= wbyte_q;
        OFF_TX_CTL: txs_q <= wbyte_q;
        OFF_BAUD: bdc_q <= wbyte_q;
        OFF_IRQ_EN1: pie_q <= wbyte_q;
        OFF_CORE_IRQ: icn_q <= wbyte_q;
        OFF_ALT_PIN: apf_q <= wbyte_q;
        OFF_ANALOG: ana_q <= wbyte_q;
        OFF_EVT_MASK: msk_q <= wbyte_q[N_EVT-1:0];
        default: ;
      endcase
    end
  end

  logic lane0_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lane0_q <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
      lane0_q <= s_axi_wstrb[0];
  end

  function automatic logic wbyte_q_valid();
    return lane0_q;
  endfunction

  // AXI read: one outstanding, answered the cycle after acceptance
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_comb
  begin
    rd_val = 8'h00;
    rd_map = 1'b1;
    unique case (s_axi_araddr)
      OFF_RX_CTL: rd_val = {rcs_q[7:4], 2'b00, ovr_q, receive_complete_flag & fifo_q[rd_ptr_q].ninth};
      OFF_TX_CTL: rd_val = {txs_q[7:4], 2'b00, ~tsr_full_q, txs_q[B_TX_NINTH]};
      OFF_BAUD: rd_val = {1'b0, rx_cnt_q == 4'h0, 1'b0, bdc_q[B_CLK_POL], 4'h0};
      OFF_RX_DATA: rd_val = receive_complete_flag ? fifo_q[rd_ptr_q].data : 8'h00;
      OFF_TX_DATA: rd_val = 8'h00;
      OFF_IRQ_EN1: rd_val = pie_q;
      OFF_IRQ_FLG1: rd_val = {2'b00, receive_complete_flag, transmit_buffer_empty_flag, 4'h0};
      OFF_CORE_IRQ: rd_val = icn_q;
      OFF_ALT_PIN: rd_val = apf_q;
      OFF_ANALOG: rd_val = ana_q;
      OFF_EVT_STAT: rd_val = 8'(evt_q);
      OFF_EVT_MASK: rd_val = 8'(msk_q);
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  sequence rx_complete_s;
    rx_on && samp && rx_last;
  endsequence

  sequence tx_handover_s;
    samp_tx && tx_last && hold_full_q && !wr_tx;
  endsequence

  mode_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (samp_tx || rx_done) |-> txs_q[B_SYNC_MODE] && rcs_q[B_PORT_EN] && !txs_q[B_CLK_SRC])
    else $error("shift without slave mode");

  analog_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ana_q[B_ANA_CLK] && $stable(bdc_q) && $stable(ana_q) |-> !samp)
    else $error("clock edge seen through analog pin");

  rx_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_complete_s ##0 !full && !pop |=> fcnt_q == $past(fcnt_q) + 1'b1 && receive_complete_flag)
    else $error("completed word not stored");

  rx_ninth_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_complete_s ##0 rcs_q[B_RX9_EN] |-> rx_word.ninth == dt_lvl)
    else $error("ninth bit not captured");

  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pop && fcnt_q == 1 && !push |=> !receive_complete_flag)
    else $error("receive flag stays after last read");

  overrun_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_complete_s ##0 full && !pop |=> ovr_q && full)
    else $error("overrun not flagged");

  ovr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !rcs_q[B_CONT_RX] |=> !ovr_q)
    else $error("overrun survives receive disable");

  tx_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_tx && !hold_full_q && rcs_q[B_PORT_EN] |=> !transmit_buffer_empty_flag ##1 (tsr_full_q || hold_full_q))
    else $error("transmit write not taken");

  tx_move_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_handover_s ##0 rcs_q[B_PORT_EN] |=> tsr_full_q && transmit_buffer_empty_flag && tx_cnt_q == 4'h0)
    else $error("holding byte not moved");

  tx_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(pie_q[B_TX_IE] && icn_q[B_PERIPH_IE]) && !(receive_complete_flag && pie_q[B_RX_IE]) |=> !core_wake)
    else $error("wake without enables");

  core_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_irq |-> $past(icn_q[B_GLOBAL_IE]) && $past(icn_q[B_PERIPH_IE]))
    else $error("core interrupt without enables");
endmodule

// ==== tb/test_usart_sync_slave_sleep.sv ====
/*
  Self-checking bench of the synchronous slave serial port: AXI4-Lite
  master tasks, a link master model and one task per scenario.
  Assumes a 250 MHz aclk and the register map of the package.
*/
module test_usart_sync_slave_sleep
  import uss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, core_sleeping, core_wake, core_irq, irq, sel;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, sck, din, dout, doe_n;
  logic [11:0] vec;
  uss_word_t r;
  int failures, checked;

  uss_top #(.RX_DEPTH(2)) i_uss_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_sleeping(core_sleeping), .core_wake(core_wake), .core_irq(core_irq), .core_irq_vector(vec),
    .irq(irq), .shift_clock_pin(sck), .data_pin_in(din), .data_pin_out(dout), .data_pin_oe_n(doe_n));

  uss_link_master i_uss_link_master (.shift_clock_pin(sck), .data_pin_in(din), .data_pin_out(dout),
    .data_pin_oe_n(doe_n), .sel(sel));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] resp = RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    check("bresp", resp, bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v, input logic [1:0] resp = RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    v = rdata[7:0];
    check("rresp", resp, rresp);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(what, exp, v);
  endtask

  // One frame from the master, then the slave's fixed sync and flag latency
  task automatic send(input int nbits, input uss_word_t w);
    i_uss_link_master.xfer(nbits, w, r);
    repeat (8) @(posedge aclk);
  endtask

  task automatic t_reset();
    rchk("rx ctl", OFF_RX_CTL, RST_CTL);
    rchk("analog", OFF_ANALOG, RST_ANALOG);
    rchk("tx data", OFF_TX_DATA, 8'h00);
    rd(8'h30, d, RESP_SLVERR);
    wr(8'h30, 8'hff, RESP_SLVERR);
    check("oe_n", 2'h3, doe_n);
    check("irq", 1'b0, irq);
    $display("reset test done");
  endtask

  task automatic t_refuse();
    wr(OFF_TX_CTL, 8'h10);
    wr(OFF_RX_CTL, 8'h90);
    send(8, 9'h0a5);
    rchk("flag analog", OFF_IRQ_FLG1, 8'h10);
    wr(OFF_ANALOG, 8'h00);
    wr(OFF_TX_CTL, 8'h90);
    core_sleeping <= 1'b1;
    send(8, 9'h0a5);
    rchk("flag master", OFF_IRQ_FLG1, 8'h10);
    core_sleeping <= 1'b0;
    wr(OFF_TX_CTL, 8'h10);
    $display("refuse test done");
  endtask

  task automatic t_rx();
    wr(OFF_RX_CTL, 8'hb0);
    wr(OFF_IRQ_EN1, 8'h20);
    wr(OFF_CORE_IRQ, 8'hc0);
    send(8, 9'h0a5);
    rchk("rx flag", OFF_IRQ_FLG1, 8'h30);
    check("core irq", 1'b1, core_irq);
    rchk("rx data", OFF_RX_DATA, 8'ha5);
    rchk("flag empty", OFF_IRQ_FLG1, 8'h10);
    check("core irq off", 1'b0, core_irq);
    wr(OFF_RX_CTL, 8'hd0);
    send(9, 9'h13c);
    rchk("ninth", OFF_RX_CTL, 8'hd1);
    rchk("rx data 9", OFF_RX_DATA, 8'h3c);
    $display("receive test done");
  endtask

  task automatic t_overrun();
    wr(OFF_RX_CTL, 8'h90);
    send(8, 9'h011);
    send(8, 9'h022);
    send(8, 9'h033);
    rchk("overrun", OFF_RX_CTL, 8'h92);
    rchk("oldest", OFF_RX_DATA, 8'h11);
    wr(OFF_RX_CTL, 8'h80);
    rchk("overrun off", OFF_RX_CTL, 8'h80);
    rchk("second", OFF_RX_DATA, 8'h22);
    rchk("drained", OFF_IRQ_FLG1, 8'h10);
    $display("overrun test done");
  endtask

  task automatic t_sleep_rx();
    wr(OFF_RX_CTL, 8'h90);
    wr(OFF_CORE_IRQ, 8'h40);
    wr(OFF_EVT_MASK, 8'h01);
    rd(OFF_EVT_STAT, d);
    core_sleeping <= 1'b1;
    send(8, 9'h05a);
    check("wake rx", 1'b1, core_wake);
    check("no global", 1'b0, core_irq);
    check("no vector", 12'h000, vec);
    check("event irq", 1'b1, irq);
    wr(OFF_CORE_IRQ, 8'hc0);
    repeat (2) @(posedge aclk);
    check("core irq on", 1'b1, core_irq);
    check("vector", IRQ_VECTOR, vec);
    rchk("evt stat", OFF_EVT_STAT, 8'h01);
    repeat (2) @(posedge aclk);
    check("event cleared", 1'b0, irq);
    core_sleeping <= 1'b0;
    rchk("sleep data", OFF_RX_DATA, 8'h5a);
    $display("sleep receive test done");
  endtask

  task automatic t_sleep_tx();
    wr(OFF_RX_CTL, 8'h80);
    wr(OFF_TX_CTL, 8'h30);
    wr(OFF_IRQ_EN1, 8'h10);
    wr(OFF_CORE_IRQ, 8'h00);
    wr(OFF_TX_DATA, 8'hc3);
    wr(OFF_TX_DATA, 8'h3c);
    rchk("tx full", OFF_IRQ_FLG1, 8'h00);
    check("driving", 1'b0, doe_n[0]);
    core_sleeping <= 1'b1;
    send(8, 9'h000);
    check("tx first", 9'h0c3, r);
    rchk("tx handover", OFF_IRQ_FLG1, 8'h10);
    check("no periph", 1'b0, core_wake);
    wr(OFF_CORE_IRQ, 8'h40);
    repeat (2) @(posedge aclk);
    check("wake tx", 1'b1, core_wake);
    wr(OFF_TX_DATA, 8'h99);
    rchk("tx refill", OFF_IRQ_FLG1, 8'h00);
    send(8, 9'h000);
    check("tx second", 9'h03c, r);
    send(8, 9'h000);
    check("tx third", 9'h099, r);
    core_sleeping <= 1'b0;
    $display("sleep transmit test done");
  endtask

  task automatic t_alt();
    wr(OFF_ALT_PIN, 8'h84);
    wr(OFF_TX_CTL, 8'h10);
    wr(OFF_RX_CTL, 8'h90);
    sel = 1'b1;
    send(8, 9'h06e);
    rchk("alt data", OFF_RX_DATA, 8'h6e);
    $display("alternate pin test done");
  endtask

  initial
  begin
    #200us;
    failures++;
    close_out();
  end

  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, core_sleeping, sel} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    failures = 0;
    checked = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_refuse();
    t_rx();
    t_overrun();
    t_sleep_rx();
    t_sleep_tx();
    t_alt();
    close_out();
  end
endmodule

// ==== tb/uss_link_master.sv ====
/*
  Behavioural synchronous master on the far side of the link: makes the
  shift clock, drives the data pin and samples the slave's answer.
  Assumes the slave samples and shifts on the falling clock edge.
*/
module uss_link_master
  import uss_pkg::*;
(
  // Pins
  output logic [1:0] shift_clock_pin,
  output logic [1:0] data_pin_in,
  input wire logic [1:0] data_pin_out,
  input wire logic [1:0] data_pin_oe_n,
  // Placement, 1 selects the alternate pins
  input wire logic sel
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    shift_clock_pin = 2'h3;
    data_pin_in = 2'h0;
  end

  // Clock idles high and only runs within a frame, LSB first
  task automatic xfer(input int nbits, input uss_word_t tx, output uss_word_t rx);
    rx = '0;
    for (int i = 0; i < nbits; i++)
    begin
      data_pin_in[sel] = tx[i];
      data_pin_in[!sel] = ~tx[i];
      #24;
      // Undriven pin reads as the inverse of the slave's output
      rx[i] = data_pin_oe_n[sel] ? ~data_pin_out[sel] : data_pin_out[sel];
      shift_clock_pin[sel] = 1'b0;
      #24;
      shift_clock_pin[sel] = 1'b1;
    end
    // Released line must not keep its last level
    data_pin_in = ~data_pin_in;
  endtask
endmodule
